// >>> rtl/qpt_top.sv
`timescale 1ns/1ns
`include "qpt_cfg.svh"

module qpt_top (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire qpt_pkg::qpt_req_s req_i,
    output logic [15:0] rd_data_o,
    input wire logic [2:0] mode_strap_i,
    input wire logic [9:0] rx_sym_i,
    input wire logic rx_vld_i,
    input wire logic false_carrier_i,
    input wire logic code_err_i,
    input wire logic disp_err_i,
    input wire logic [9:0] tx_sym_i,
    input wire logic [3:0] port_pd_i,
    output logic [9:0] tx_sym_o,
    output logic rx_err_sym_o,
    output logic port_rst_o,
    output logic [3:0] port_pd_o,
    output logic glb_pd_o,
    output logic ref_sel_o,
    output logic irq_o
);
    import qpt_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Ten steps of the pattern engine, newest bit at hist[0]
    function automatic qpt_step_s pat_step(
        input logic [30:0] h,
        input logic [9:0] din,
        input logic [1:0] sel,
        input logic gen
    );
        qpt_step_s r;
        logic p;
        logic b;
        r = '0;
        for (int i = 9; i >= 0; i--) begin
            case (sel)
                2'b11: p = ~h[0];
                2'b10: p = h[30] ^ h[27];
                2'b01: p = h[22] ^ h[17];
                default: p = h[6] ^ h[5];
            endcase
            b = gen ? p : din[i];
            r.bits[i] = b;
            r.errs = r.errs + {3'b000, b ^ p};
            h = {h[29:0], b};
        end
        r.hist = h;
        return r;
    endfunction

    // Polarity bit 1 passes the symbol, 0 inverts it
    function automatic logic [9:0] pol_fix(
        input logic [9:0] d,
        input logic keep
    );
        return d ^ {10{~keep}};
    endfunction

    ////////////////////////////////////////////////////////////////////
    qpt_state_s s_q;
    qpt_state_s s_d;
    qpt_step_s gen_r;
    qpt_step_s chk_r;
    logic [9:0] rx_line;
    logic [9:0] chk_in;
    logic sym_err;
    logic rx_evt;
    logic pat_evt;
    logic lock_evt;
    logic done_evt;
    logic cnt_run;
    logic [32:0] sum;
    logic [3:0] evt;
    logic [1:0] sel;

    // Pattern engines and line polarity
    always_comb begin
        sel = s_q.ctl[`QPT_CTL_SEL_HI:`QPT_CTL_SEL_LO];
        rx_line = pol_fix(rx_sym_i, s_q.glb[`QPT_GLB_RX_POL]);
        chk_in = pol_fix(rx_line, s_q.ctl[`QPT_CTL_CHK_POL]);
        gen_r = pat_step(s_q.gen_hist, 10'h000, sel, 1'b1);
        chk_r = pat_step(s_q.chk_hist, chk_in, sel, 1'b0);
    end

    ////////////////////////////////////////////////////////////////////
    // Next state of the whole block
    always_comb begin
        s_d = s_q;
        s_d.rdata = 16'h0000;
        s_d.clr = 1'b0;
        lock_evt = 1'b0;
        done_evt = 1'b0;
        pat_evt = 1'b0;
        sum = 33'h0_0000_0000;

        // Symbol error with optional disparity check
        sym_err = code_err_i
            | (disp_err_i & s_q.glb[`QPT_GLB_DISP]);
        rx_evt = false_carrier_i | sym_err;
        s_d.rx_err_sym = sym_err;
        if (rx_evt && s_q.rx_cnt != 16'hffff) begin
            s_d.rx_cnt = s_q.rx_cnt + 16'h0001;
        end

        // Generator advances only while enabled
        if (s_q.ctl[`QPT_CTL_GEN_EN]) begin
            s_d.gen_hist = gen_r.hist;
        end

        // Checker, lock tracking and error count
        cnt_run = s_q.ctl[`QPT_CTL_CHK_EN]
            && (!s_q.ctl[`QPT_CTL_LOCK] || s_q.locked);
        if (!s_q.ctl[`QPT_CTL_CHK_EN]) begin
            s_d.locked = 1'b0;
            s_d.clean = 4'h0;
        end else if (rx_vld_i) begin
            s_d.chk_hist = chk_r.hist;
            if (chk_r.errs != 4'h0) begin
                s_d.clean = 4'h0;
                pat_evt = 1'b1;
            end else if (!s_q.locked) begin
                s_d.clean = s_q.clean + 4'h1;
                if (s_q.clean + 4'h1 >= `QPT_LOCK_SYMS) begin
                    s_d.locked = 1'b1;
                    lock_evt = 1'b1;
                end
            end
            if (cnt_run) begin
                sum = {1'b0, s_q.pat_cnt} + {29'h0, chk_r.errs};
                s_d.pat_cnt = sum[32] ? 32'hffff_ffff
                    : sum[31:0];
            end
        end
        if (s_q.clr) begin
            s_d.pat_cnt = 32'h0000_0000;
            s_d.hi_snap = 16'h0000;
            s_d.locked = 1'b0;
            s_d.clean = 4'h0;
        end

        // Register reads
        if (req_i.re) begin
            case (req_i.addr)
                `QPT_OFS_RX_ERR: s_d.rdata = s_q.rx_cnt;
                `QPT_OFS_CTL: begin
                    s_d.rdata = s_q.ctl;
                    s_d.rdata[`QPT_CTL_CLR] = s_q.clr;
                end
                `QPT_OFS_CNT_LO: begin
                    s_d.rdata = s_q.pat_cnt[15:0];
                    if (!s_q.clr) begin
                        s_d.hi_snap = s_q.pat_cnt[31:16];
                    end
                end
                `QPT_OFS_CNT_HI: s_d.rdata = s_q.hi_snap;
                `QPT_OFS_GLB: begin
                    s_d.rdata = s_q.glb;
                    s_d.rdata[`QPT_GLB_RST] = s_q.rst_st == QPT_BUSY;
                end
                `QPT_OFS_IRQ_STS: s_d.rdata = {12'h000, s_q.sts};
                `QPT_OFS_IRQ_MSK: s_d.rdata = {12'h000, s_q.msk};
                default: s_d.rdata = 16'h0000;
            endcase
        end

        // Register writes
        if (req_i.we) begin
            case (req_i.addr)
                `QPT_OFS_CTL: begin
                    s_d.ctl = req_i.wdata;
                    s_d.ctl[`QPT_CTL_CLR] = 1'b0;
                    s_d.clr = req_i.wdata[`QPT_CTL_CLR];
                end
                `QPT_OFS_GLB: begin
                    s_d.glb = req_i.wdata;
                    s_d.glb[`QPT_GLB_RST] = 1'b0;
                end
                `QPT_OFS_IRQ_MSK: s_d.msk = req_i.wdata[3:0];
                default: ;
            endcase
        end

        // Global reset sequencer
        case (s_q.rst_st)
            QPT_IDLE: begin
                if (req_i.we && req_i.addr == `QPT_OFS_GLB
                    && req_i.wdata[`QPT_GLB_RST]) begin
                    s_d.rst_st = QPT_BUSY;
                    s_d.rst_cnt = `QPT_RST_CYC;
                    s_d.ctl[`QPT_CTL_CHK_EN] = 1'b0;
                    s_d.ctl[`QPT_CTL_GEN_EN] = 1'b0;
                    s_d.clr = 1'b0;
                    s_d.glb[`QPT_GLB_LPBK] = 1'b0;
                    s_d.ref_sel = s_d.glb[`QPT_GLB_REF_SEL];
                end
            end
            QPT_BUSY: begin
                s_d.rst_cnt = s_q.rst_cnt - 8'h01;
                if (s_q.rst_cnt == 8'h01) begin
                    s_d.rst_st = QPT_IDLE;
                    done_evt = 1'b1;
                end
            end
            default: s_d.rst_st = QPT_IDLE;
        endcase
        s_d.port_rst = s_d.rst_st == QPT_BUSY;

        // Power control
        s_d.glb_pd = s_d.glb[`QPT_GLB_PD];
        s_d.port_pd = s_d.glb[`QPT_GLB_PD] ? 4'hf
            : port_pd_i;

        // Transmit symbol selection
        if (s_q.glb[`QPT_GLB_LPBK]) begin
            s_d.tx_sym = rx_line;
        end else if (s_q.ctl[`QPT_CTL_GEN_EN]) begin
            s_d.tx_sym = pol_fix(gen_r.bits,
                s_q.ctl[`QPT_CTL_GEN_POL]);
        end else begin
            s_d.tx_sym = tx_sym_i;
        end
        s_d.tx_sym = pol_fix(s_d.tx_sym,
            s_q.glb[`QPT_GLB_TX_POL]);

        // Interrupt status, set wins over write-one clear
        evt = 4'h0;
        evt[`QPT_IRQ_RX_ERR] = rx_evt;
        evt[`QPT_IRQ_PAT_ERR] = pat_evt;
        evt[`QPT_IRQ_LOCK] = lock_evt;
        evt[`QPT_IRQ_RST_DONE] = done_evt;
        if (req_i.we && req_i.addr == `QPT_OFS_IRQ_STS) begin
            s_d.sts = s_q.sts & ~req_i.wdata[3:0];
        end
        s_d.sts = s_d.sts | evt;
        s_d.irq = |(s_d.sts & s_d.msk);
    end

    ////////////////////////////////////////////////////////////////////
    // State register with hardware reset and power strap
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            s_q <= '0;
            s_q.ctl <= `QPT_CTL_RST;
            s_q.glb <= `QPT_GLB_RST_VAL;
            s_q.glb[`QPT_GLB_PD] <= mode_strap_i == `QPT_PD_STRAP;
            s_q.glb_pd <= mode_strap_i == `QPT_PD_STRAP;
            s_q.port_pd <= {4{mode_strap_i == `QPT_PD_STRAP}};
            s_q.gen_hist <= `QPT_HIST_SEED;
            s_q.chk_hist <= `QPT_HIST_SEED;
            s_q.rst_st <= QPT_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign rd_data_o = s_q.rdata;
    assign tx_sym_o = s_q.tx_sym;
    assign rx_err_sym_o = s_q.rx_err_sym;
    assign port_rst_o = s_q.port_rst;
    assign port_pd_o = s_q.port_pd;
    assign glb_pd_o = s_q.glb_pd;
    assign ref_sel_o = s_q.ref_sel;
    assign irq_o = s_q.irq;

endmodule

// >>> include/qpt_cfg.svh
// Operation
// - Receive error counter pegs at 0xFFFF
// - False carrier and symbol errors both count
// - Polarity bit 1 passes, 0 inverts
// - Lock-wait delays counting until checker locks
// - Clear-counter bit clears, then self clears
// - Select 11 emits alternating 1010 pattern
// - Select picks PRBS31, PRBS23 or PRBS7
// - Own enables; software reset clears both
// - Low-half read snapshots the upper half
// - Only clear-counter bit clears pattern counter
// - Global reset resets ports, self clears
// - Clock select applies after software reset
// - Global power-down overrides per-port power
// - Strap 001 loads power-down at reset
// - Raw loopback returns undecoded input symbols
// - Disparity check gates symbol error
`ifndef QPT_CFG_SVH
`define QPT_CFG_SVH

// Register offsets
`define QPT_OFS_RX_ERR 8'h15
`define QPT_OFS_CTL 8'h17
`define QPT_OFS_CNT_LO 8'h18
`define QPT_OFS_CNT_HI 8'h19
`define QPT_OFS_GLB 8'h1a
`define QPT_OFS_IRQ_STS 8'h1c
`define QPT_OFS_IRQ_MSK 8'h1d

// Test control field positions
`define QPT_CTL_CHK_POL 7
`define QPT_CTL_GEN_POL 6
`define QPT_CTL_LOCK 5
`define QPT_CTL_CLR 4
`define QPT_CTL_SEL_HI 3
`define QPT_CTL_SEL_LO 2
`define QPT_CTL_CHK_EN 1
`define QPT_CTL_GEN_EN 0

// Global control field positions
`define QPT_GLB_RST 15
`define QPT_GLB_REF_SEL 14
`define QPT_GLB_RX_POL 13
`define QPT_GLB_TX_POL 12
`define QPT_GLB_PD 11
`define QPT_GLB_LPBK 9
`define QPT_GLB_DISP 3

// Reset values and strap
`define QPT_CTL_RST 16'h0000
`define QPT_GLB_RST_VAL 16'h3002
`define QPT_PD_STRAP 3'h1
`define QPT_HIST_SEED 31'h7fff_ffff

// Timing counts: reset in clock cycles, lock in clean received symbols
`define QPT_RST_CYC 8'h10
`define QPT_LOCK_SYMS 4'h4

// Interrupt status bit positions
`define QPT_IRQ_RX_ERR 0
`define QPT_IRQ_PAT_ERR 1
`define QPT_IRQ_LOCK 2
`define QPT_IRQ_RST_DONE 3

`endif

// >>> include/qpt_pkg.sv
package qpt_pkg;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic we;
        logic re;
    } qpt_req_s;

    // Global reset sequencer states
    typedef enum logic [1:0] {
        QPT_IDLE = 2'b01,
        QPT_BUSY = 2'b10
    } qpt_rst_e;

    // Result of ten pattern steps
    typedef struct packed {
        logic [30:0] hist;
        logic [9:0] bits;
        logic [3:0] errs;
    } qpt_step_s;

    // Whole state of the block
    typedef struct packed {
        logic [15:0] ctl;
        logic [15:0] glb;
        logic clr;
        logic [15:0] rx_cnt;
        logic [31:0] pat_cnt;
        logic [15:0] hi_snap;
        logic [30:0] gen_hist;
        logic [30:0] chk_hist;
        logic locked;
        logic [3:0] clean;
        qpt_rst_e rst_st;
        logic [7:0] rst_cnt;
        logic [3:0] sts;
        logic [3:0] msk;
        logic [15:0] rdata;
        logic [9:0] tx_sym;
        logic rx_err_sym;
        logic port_rst;
        logic [3:0] port_pd;
        logic glb_pd;
        logic ref_sel;
        logic irq;
    } qpt_state_s;

endpackage

// >>> tb/qpt_props.sv
`timescale 1ns/1ns
`include "qpt_cfg.svh"

module qpt_props (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire qpt_pkg::qpt_req_s req_i,
    input wire logic [15:0] rd_data_o,
    input wire logic [2:0] mode_strap_i,
    input wire logic code_err_i,
    input wire logic disp_err_i,
    input wire logic rx_err_sym_o,
    input wire logic port_rst_o,
    input wire logic [3:0] port_pd_o,
    input wire logic glb_pd_o,
    input wire logic ref_sel_o
);
    import qpt_pkg::*;

    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (!rst_b_i);

    // Write of the global reset bit
    sequence s_rst_wr;
        req_i.we && req_i.addr == `QPT_OFS_GLB && req_i.wdata[15];
    endsequence
    // Reset pulse of exactly sixteen cycles
    sequence s_rst_pulse;
        port_rst_o [*8] ##1 port_rst_o [*8] ##1 !port_rst_o;
    endsequence

    a_rd_idle: assert property (
        !req_i.re |=> rd_data_o == 16'h0000)
        else $error("read data not idle");
    a_err_cause: assert property (
        rx_err_sym_o |-> $past(code_err_i) || $past(disp_err_i))
        else $error("error symbol without cause");
    a_code_err_flag: assert property (
        code_err_i |=> rx_err_sym_o)
        else $error("code error not flagged");
    a_rst_start: assert property (s_rst_wr |=> s_rst_pulse)
        else $error("global reset pulse wrong");
    a_rst_cause: assert property (
        $rose(port_rst_o) |-> $past(req_i.we))
        else $error("port reset without write");
    a_pd_all: assert property (glb_pd_o |-> port_pd_o == 4'hf)
        else $error("global power-down not applied");
    a_ref_hold: assert property (
        $changed(ref_sel_o) |-> port_rst_o || $past(port_rst_o))
        else $error("clock select changed outside reset");
    a_strap_pd: assert property (
        $rose(rst_b_i) |-> glb_pd_o == (mode_strap_i == `QPT_PD_STRAP))
        else $error("strap power-down wrong");
endmodule

bind qpt_top qpt_props u_props (.mclk_i, .rst_b_i, .req_i, .rd_data_o,
    .mode_strap_i, .code_err_i, .disp_err_i, .rx_err_sym_o, .port_rst_o,
    .port_pd_o, .glb_pd_o, .ref_sel_o);

// >>> tb/qpt_far_end.sv
`timescale 1ns/1ns

module qpt_far_end (
    input wire logic mclk_i,
    input wire logic echo_i,
    input wire logic flip_i,
    input wire logic [9:0] sym_i,
    input wire logic [9:0] tx_sym_i,
    output logic [9:0] rx_sym_o,
    output logic rx_vld_o
);
    assign rx_vld_o = 1'b1;
    // Sends its own symbol or echoes ours, on the shared clock
    always @(posedge mclk_i) begin
        rx_sym_o <= (echo_i ? tx_sym_i : sym_i) ^ {10{flip_i}};
    end
endmodule

// >>> tb/qpt_top_bench.sv
`timescale 1ns/1ns

module qpt_top_bench;
    import qpt_pkg::*;
    typedef struct packed {
        logic [7:0] a; logic w; logic [15:0] d; logic [15:0] e;
    } qpt_row_s;
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    qpt_req_s req_i = '0;
    logic [2:0] mode_strap_i = 3'h0;
    logic false_carrier_i = 1'b0, code_err_i = 1'b0, disp_err_i = 1'b0;
    logic [9:0] tx_sym_i = 10'h17c, sym = 10'h2a5, rx_sym_i, tx_sym_o;
    logic [3:0] port_pd_i = 4'h5, port_pd_o;
    logic echo = 1'b0, flip = 1'b0, rx_vld_i, rx_err_sym_o;
    logic port_rst_o, glb_pd_o, ref_sel_o, irq_o;
    logic [15:0] rd_data_o, v, w;
    int err_count = 0, samples_checked = 0, cyc = 0, n, j, bad;
    logic [19:0] st;
    qpt_row_s rows [8] = '{'{8'h15, 1'b0, 16'h0000, 16'h0000},
        '{8'h17, 1'b0, 16'h0000, 16'h0000}, '{8'h18, 1'b0, 16'h0000, 16'h0000},
        '{8'h19, 1'b0, 16'h0000, 16'h0000}, '{8'h1a, 1'b0, 16'h0000, 16'h3002},
        '{8'h33, 1'b1, 16'h1234, 16'h0000}, '{8'h15, 1'b1, 16'hffff, 16'h0000},
        '{8'h17, 1'b1, 16'hff0c, 16'hff0c}};

    qpt_top dut (.mclk_i, .rst_b_i, .req_i, .rd_data_o, .mode_strap_i,
        .rx_sym_i, .rx_vld_i, .false_carrier_i, .code_err_i, .disp_err_i,
        .tx_sym_i, .port_pd_i, .tx_sym_o, .rx_err_sym_o, .port_rst_o,
        .port_pd_o, .glb_pd_o, .ref_sel_o, .irq_o);
    qpt_far_end far (.mclk_i, .echo_i(echo), .flip_i(flip), .sym_i(sym),
        .tx_sym_i(tx_sym_o), .rx_sym_o(rx_sym_i), .rx_vld_o(rx_vld_i));

    ////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    always #5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 90000) begin
            err_count++;
            summarize();
        end
    end

    task automatic chk(input string nm, input logic [15:0] e, g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        req_i <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge mclk_i);
        req_i.we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge mclk_i);
        req_i <= '{addr: a, wdata: 16'h0000, we: 1'b0, re: 1'b1};
        @(posedge mclk_i);
        req_i.re <= 1'b0;
        #1 d = rd_data_o;
    endtask
    task automatic summarize;
        $display("Checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (4) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d);
            rd(rows[i].a, v);
            chk("reg", rows[i].e, v);
        end
        wr(8'h1a, 16'h3202);
        repeat (2) @(posedge mclk_i);
        #1 chk("loop", {6'h00, sym}, {6'h00, tx_sym_o});
        wr(8'h1a, 16'h2202);
        repeat (2) @(posedge mclk_i);
        #1 chk("txpol", {6'h00, ~sym}, {6'h00, tx_sym_o});
        wr(8'h1a, 16'h3002);
        echo <= 1'b1;
        flip <= 1'b1;
        wr(8'h17, 16'h0023);
        repeat (30) @(posedge mclk_i);
        rd(8'h18, v);
        chk("lockwait", 16'h0000, v);
        wr(8'h17, 16'h0003);
        repeat (7000) @(posedge mclk_i);
        rd(8'h18, v);
        chk("count", 16'h0001, {15'h0000, v != 16'h0000});
        repeat (20) @(posedge mclk_i);
        rd(8'h19, w);
        chk("snaphi", 16'h0001, w);
        flip <= 1'b0;
        repeat (10) @(posedge mclk_i);
        rd(8'h18, v);
        rd(8'h18, w);
        chk("rdkeep", v, w);
        for (n = 0; n < 4; n++) begin
            wr(8'h17, {12'h000, n[1:0], 2'b11});
            repeat (40) @(posedge mclk_i);
            // Inverted seven-bit sequence obeys its recurrence on the line
            if (n == 0) begin
                #1 st[19:10] = tx_sym_o;
                @(posedge mclk_i);
                #1 st[9:0] = tx_sym_o;
                bad = 0;
                for (j = 0; j < 13; j++) begin
                    bad += int'(st[j] !== ~(st[j + 7] ^ st[j + 6]));
                end
                chk("poly7", 16'h0000, bad[15:0]);
            end
            wr(8'h17, {11'h000, 1'b1, n[1:0], 2'b11});
            repeat (40) @(posedge mclk_i);
            rd(8'h19, w);
            chk("prbshi", 16'h0000, w);
            rd(8'h18, v);
            chk("prbs", 16'h0000, v);
        end
        chk("alt", 16'h0001, {15'h0000,
            tx_sym_o == 10'h2aa || tx_sym_o == 10'h155});
        rd(8'h17, v);
        chk("clrbit", 16'h000f, v);
        @(posedge mclk_i);
        code_err_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        code_err_i <= 1'b0;
        false_carrier_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        false_carrier_i <= 1'b0;
        rd(8'h15, v);
        chk("rxcnt", 16'h0005, v);
        for (n = 0; n < 2; n++) begin
            wr(8'h1a, {12'h300, n[0], 3'h2});
            @(posedge mclk_i);
            disp_err_i <= 1'b1;
            @(posedge mclk_i);
            disp_err_i <= 1'b0;
            #1 chk("disp", {15'h0000, n[0]},
                {15'h0000, rx_err_sym_o});
        end
        @(posedge mclk_i);
        false_carrier_i <= 1'b1;
        repeat (65540) @(posedge mclk_i);
        false_carrier_i <= 1'b0;
        rd(8'h15, v);
        chk("rxsat", 16'hffff, v);
        wr(8'h1d, 16'h0001);
        repeat (2) @(posedge mclk_i);
        #1 chk("irq", 16'h0001, {15'h0000, irq_o});
        wr(8'h1c, 16'h000f);
        repeat (2) @(posedge mclk_i);
        #1 chk("irqclr", 16'h0000, {15'h0000, irq_o});
        wr(8'h1a, 16'h7002);
        repeat (3) @(posedge mclk_i);
        #1 chk("refhold", 16'h0000, {15'h0000, ref_sel_o});
        wr(8'h1a, 16'hf002);
        n = 0;
        repeat (40) begin
            #1 n += int'(port_rst_o === 1'b1);
            @(posedge mclk_i);
        end
        chk("rstlen", 16'h0010, n[15:0]);
        chk("refsel", 16'h0001, {15'h0000, ref_sel_o});
        rd(8'h1a, v);
        chk("glbsc", 16'h7002, v);
        rd(8'h17, v);
        chk("enclr", 16'h000c, v);
        chk("pdport", 16'h0005, {12'h000, port_pd_o});
        wr(8'h1a, 16'h7802);
        repeat (2) @(posedge mclk_i);
        #1 chk("pdall", 16'h001f, {11'h000, glb_pd_o, port_pd_o});
        @(posedge mclk_i);
        mode_strap_i <= 3'h1;
        rst_b_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        rd(8'h1a, v);
        chk("strap", 16'h3802, v);
        summarize();
    end
endmodule
